// ==== logic/pin_wake_pkg.sv ====
// constants shared by the pin wake unit
package pin_wake_pkg;
    localparam int NUM_PINS = 8;
    localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_PIN_ENABLE = 2'h1;
    localparam logic [1:0] ADDR_POLARITY = 2'h2;
    localparam int BIT_DETECT_MODE = 0;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_ACKNOWLEDGE = 2;
    localparam int BIT_EVENT_FLAG = 3;
    localparam logic [7:0] RESET_PIN_ENABLE = 8'h00;
    localparam logic [7:0] RESET_POLARITY = 8'h00;
    localparam logic RESET_MODE = 1'b0;
    localparam logic RESET_IRQ_ENABLE = 1'b0;
    localparam logic [7:0] RESET_INPUTS = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // run and low power modes as seen by the block
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_STOP3 = 2'b11,
        PWR_DEEP = 2'b10
    } power_mode_t;
endpackage

// ==== logic/pin_edge_detect.sv ====
`timescale 1ns/100ps
// per pin assertion, edge and level detection
module pin_edge_detect
    import pin_wake_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic clear,
    // configuration
    input wire logic [NUM_PINS-1:0] enable,
    input wire logic [NUM_PINS-1:0] polarity,
    // pins
    input wire logic [NUM_PINS-1:0] pins,
    // results
    output logic [NUM_PINS-1:0] edge_hit,
    output logic [NUM_PINS-1:0] asserted
);
    logic [NUM_PINS-1:0] armed_ff;
    logic [NUM_PINS-1:0] prev_ff;

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            // asserted level after polarity
            assign asserted[i] = enable[i] & (pins[i] ^ ~polarity[i]);
            // R9: R10: edge is deasserted then asserted sample
            assign edge_hit[i] = armed_ff[i] & prev_ff[i] == 1'b0 & asserted[i];
            always_ff @(posedge clk) begin
                if (clear || !enable[i]) begin
                    prev_ff[i] <= 1'b1;
                    armed_ff[i] <= 1'b0;
                end else begin
                    prev_ff[i] <= asserted[i];
                    // R11: arm only once deasserted level is seen
                    if (!asserted[i]) begin
                        armed_ff[i] <= 1'b1;
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== logic/pin_pull_select.sv ====
`timescale 1ns/100ps
// pull resistor type selection per pin
module pin_pull_select
    import pin_wake_pkg::*;
(
    // configuration
    input wire logic [NUM_PINS-1:0] pull_enable,
    input wire logic [NUM_PINS-1:0] pin_enable,
    input wire logic [NUM_PINS-1:0] polarity,
    // resistor controls
    output logic [NUM_PINS-1:0] pull_up,
    output logic [NUM_PINS-1:0] pull_down
);
    // R15: polarity 1 on an enabled pin gives pulldown, pullup otherwise
    assign pull_up = pull_enable & ~(pin_enable & polarity);
    assign pull_down = pull_enable & pin_enable & polarity;
endmodule

// ==== logic/pin_wake_unit.sv ====
// Functional notes
// R1: debug mode does not stop detection or flag updates.
// R2: status bits 7:4 read zero.
// R3: status bit 3 is the read-only event flag.
// R4: status bit 2 is write-one acknowledge, reads zero.
// R5: status bit 1 enables the interrupt request.
// R6: status bit 0 selects edge only or edge plus level.
// R7: pin enable register, one bit per pin.
// R8: polarity register, 0 falling/low, 1 rising/high.
// R9: falling edge is 1 then 0 on consecutive clocks.
// R10: rising edge is 0 then 1 on consecutive clocks.
// R11: edges count only after the deasserted level is seen.
// R12: edge mode flag holds until acknowledged.
// R13: level mode sets flag on edge or asserted level.
// R14: level mode acknowledge clears only when all enabled pins deasserted.
// R15: polarity bit chooses pullup or pulldown when pull enabled; disabled pins always get pullup. Code gives them pullup only when PORT_PULL_ENABLE is set.
// R16: software masks, configures, enables, acknowledges, then unmasks.
// R17: shallow stop keeps detection running to wake the processor.
// R18: deep stop disables unit and restores reset state.
// R19: wait mode keeps the unit operating.
// R20: request is flag and enable, held until cleared.
// R21: reset clears all flags and configuration.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
module pin_wake_unit
    import pin_wake_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // processor state
    input wire logic [1:0] POWER_MODE,
    input wire logic DEBUG_MODE,
    // pins and pull control
    input wire logic [NUM_PINS-1:0] WAKE_INPUT_PIN,
    input wire logic [NUM_PINS-1:0] PORT_PULL_ENABLE,
    output logic [NUM_PINS-1:0] PULL_UP,
    output logic [NUM_PINS-1:0] PULL_DOWN,
    // interrupt request and wakeup
    output logic IRQ,
    output logic WAKE
);
    logic [NUM_PINS-1:0] pin_enable_bits_ff;
    logic [NUM_PINS-1:0] polarity_bits_ff;
    logic detect_mode_bit_ff;
    logic irq_enable_bit_ff;
    logic event_flag_ff;
    logic [NUM_PINS-1:0] pin_sample_ff;
    logic [NUM_PINS-1:0] edge_hit;
    logic [NUM_PINS-1:0] asserted;
    logic [NUM_PINS-1:0] nxt_pull_up;
    logic [NUM_PINS-1:0] nxt_pull_down;
    logic deep_stop;
    logic clear;
    logic ack_write;
    logic set_event;
    logic nxt_event_flag;
    logic [7:0] nxt_rdata;

    // R18: deep stop holds all but the read data and pull registers in reset
    assign deep_stop = (POWER_MODE == PWR_DEEP);
    assign clear = SYS_RST | deep_stop;
    // R1: R17: R19: DEBUG_MODE and the other power modes do not gate detection
    assign ack_write = WR && ADDR == ADDR_STATUS_CONTROL && WDATA[BIT_ACKNOWLEDGE];

    // input sampling register; synchronous to CLK by assumption
    always_ff @(posedge CLK) begin
        if (clear) begin
            pin_sample_ff <= RESET_INPUTS;
        end else begin
            pin_sample_ff <= WAKE_INPUT_PIN;
        end
    end

    pin_edge_detect u_detect (
        .clk(CLK),
        .clear(clear),
        .enable(pin_enable_bits_ff),
        .polarity(polarity_bits_ff),
        .pins(pin_sample_ff),
        .edge_hit(edge_hit),
        .asserted(asserted)
    );

    pin_pull_select u_pull (
        .pull_enable(PORT_PULL_ENABLE),
        .pin_enable(pin_enable_bits_ff),
        .polarity(polarity_bits_ff),
        .pull_up(nxt_pull_up),
        .pull_down(nxt_pull_down)
    );

    // R21: configuration registers reset to zero
    always_ff @(posedge CLK) begin
        if (clear) begin
            pin_enable_bits_ff <= RESET_PIN_ENABLE;
            polarity_bits_ff <= RESET_POLARITY;
            detect_mode_bit_ff <= RESET_MODE;
            irq_enable_bit_ff <= RESET_IRQ_ENABLE;
        end else if (WR) begin
            if (ADDR == ADDR_STATUS_CONTROL) begin
                // R6: mode select
                detect_mode_bit_ff <= WDATA[BIT_DETECT_MODE];
                // R5: interrupt enable
                irq_enable_bit_ff <= WDATA[BIT_IRQ_ENABLE];
            end else if (ADDR == ADDR_PIN_ENABLE) begin
                // R7: pin enables
                pin_enable_bits_ff <= WDATA;
            end else if (ADDR == ADDR_POLARITY) begin
                // R8: polarity selects
                polarity_bits_ff <= WDATA;
            end
        end
    end

    // R12: R13: set sources depend on mode
    assign set_event = (|edge_hit) | (detect_mode_bit_ff & (|asserted));

    // event flag; set wins over acknowledge in the same cycle
    always_comb begin
        nxt_event_flag = event_flag_ff;
        // R14: level mode refuses clear while any enabled pin asserted
        if (ack_write && !(detect_mode_bit_ff && (|asserted))) begin
            nxt_event_flag = 1'b0;
        end
        if (set_event) begin
            nxt_event_flag = 1'b1;
        end
    end

    // R3: flag changes only by hardware or acknowledge
    always_ff @(posedge CLK) begin
        if (clear) begin
            event_flag_ff <= 1'b0;
        end else begin
            event_flag_ff <= nxt_event_flag;
        end
    end

    // read mux; unused bits and unmapped addresses read zero
    always_comb begin
        nxt_rdata = READ_UNMAPPED;
        if (ADDR == ADDR_STATUS_CONTROL) begin
            // R2: R4: upper nibble and acknowledge read zero
            nxt_rdata[BIT_EVENT_FLAG] = event_flag_ff;
            nxt_rdata[BIT_IRQ_ENABLE] = irq_enable_bit_ff;
            nxt_rdata[BIT_DETECT_MODE] = detect_mode_bit_ff;
        end else if (ADDR == ADDR_PIN_ENABLE) begin
            nxt_rdata = pin_enable_bits_ff;
        end else if (ADDR == ADDR_POLARITY) begin
            nxt_rdata = polarity_bits_ff;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (SYS_RST || !RD) begin
            RDATA <= READ_UNMAPPED;
        end else begin
            RDATA <= nxt_rdata;
        end
    end

    // R20: request follows flag and enable, wakeup also needs a non-run mode, one cycle later
    always_ff @(posedge CLK) begin
        if (clear) begin
            IRQ <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            IRQ <= event_flag_ff & irq_enable_bit_ff;
            WAKE <= event_flag_ff & irq_enable_bit_ff & (POWER_MODE != PWR_RUN);
        end
    end

    // pull resistor controls registered for clean outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PULL_UP <= '0;
            PULL_DOWN <= '0;
        end else begin
            PULL_UP <= nxt_pull_up;
            PULL_DOWN <= nxt_pull_down;
        end
    end
endmodule

// ==== dv/pin_wake_unit_asserts.sv ====
// port checker for the pin wake unit
`timescale 1ns/100ps
module pin_wake_unit_asserts
    import pin_wake_pkg::*;
(
    // clock, reset and register port
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // mode, pulls and request
    input wire logic [1:0] POWER_MODE,
    input wire logic [NUM_PINS-1:0] PORT_PULL_ENABLE,
    input wire logic [NUM_PINS-1:0] PULL_UP,
    input wire logic [NUM_PINS-1:0] PULL_DOWN,
    input wire logic IRQ,
    input wire logic WAKE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // status write that masks the request
    sequence mask_wr;
        WR && ADDR == ADDR_STATUS_CONTROL && !WDATA[BIT_IRQ_ENABLE];
    endsequence
    stat_zero_a: assert property (RD && ADDR == ADDR_STATUS_CONTROL |=>
        RDATA[7:4] == 4'h0 && !RDATA[BIT_ACKNOWLEDGE]) else $error("spare bits set");
    irq_mask_a: assert property (mask_wr |-> ##2 !IRQ) else $error("masked request");
    irq_hold_a: assert property (IRQ && !(WR && ADDR == ADDR_STATUS_CONTROL)
        && !$past(WR && ADDR == ADDR_STATUS_CONTROL) && POWER_MODE != PWR_DEEP
        && !$past(POWER_MODE == PWR_DEEP) |=> IRQ) else $error("request dropped");
    wake_run_a: assert property (POWER_MODE == PWR_RUN |=> !WAKE)
        else $error("wake in run");
    wake_irq_a: assert property (WAKE |-> IRQ) else $error("wake without request");
    deep_reset_a: assert property (POWER_MODE == PWR_DEEP |-> ##2 !IRQ && !WAKE)
        else $error("deep stop kept state");
    pull_split_a: assert property (!$past(SYS_RST) |-> (PULL_UP & PULL_DOWN) == 8'h00
        && (PULL_UP | PULL_DOWN) == $past(PORT_PULL_ENABLE)) else $error("pull mix");
    reset_clean_a: assert property ($fell(SYS_RST) |-> !IRQ && !WAKE)
        else $error("request after reset");
endmodule

bind pin_wake_unit pin_wake_unit_asserts pin_wake_unit_asserts_inst (.CLK(CLK),
    .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .POWER_MODE(POWER_MODE), .PORT_PULL_ENABLE(PORT_PULL_ENABLE), .PULL_UP(PULL_UP),
    .PULL_DOWN(PULL_DOWN), .IRQ(IRQ), .WAKE(WAKE));

// ==== dv/pin_switch_model.sv ====
// switches to ground on the wake input pins
`timescale 1ns/100ps
module pin_switch_model
    import pin_wake_pkg::*;
(
    // clock and pacing
    input wire logic clk,
    input wire logic slow,
    // switch state and pulldowns
    input wire logic [NUM_PINS-1:0] closed,
    input wire logic [NUM_PINS-1:0] pull_down,
    // pin levels
    output logic [NUM_PINS-1:0] pins
);
    logic [NUM_PINS-1:0] lag_ff;
    // pull sets level
    // closed pins go low, open pins go to the pull level, high with no pulldown; slow contacts settle a cycle late
    always_ff @(posedge clk) begin
        lag_ff <= ~closed & ~pull_down;
        pins <= slow ? lag_ff : ~closed & ~pull_down;
    end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the pin wake unit
`timescale 1ns/100ps
module testbench
    import pin_wake_pkg::*;
;
    localparam logic [1:0] sc = ADDR_STATUS_CONTROL;
    logic clk, irq, wake;
    logic sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, dbg = 1'b0, slow = 1'b0;
    logic [1:0] addr = 2'h0, pmode = 2'h0;
    logic [7:0] wdata = 8'h00, pull_en = 8'h00, closed = 8'h00;
    logic [7:0] rdata, pins, pull_up, pull_dn;
    int error_cnt = 0, check_count = 0;
    // design and the switches on its pins
    pin_wake_unit pin_wake_unit_inst (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .POWER_MODE(pmode), .DEBUG_MODE(dbg),
        .WAKE_INPUT_PIN(pins), .PORT_PULL_ENABLE(pull_en), .PULL_UP(pull_up),
        .PULL_DOWN(pull_dn), .IRQ(irq), .WAKE(wake));
    pin_switch_model pin_switch_model_inst (.clk(clk), .slow(slow), .closed(closed),
        .pull_down(pull_dn), .pins(pins));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
        @(posedge clk);
    endtask
    task automatic t_regs();
        rreg(sc, 8'h00);
        rreg(ADDR_PIN_ENABLE, RESET_PIN_ENABLE);
        rreg(ADDR_POLARITY, RESET_POLARITY);
        rreg(2'h3, READ_UNMAPPED);
        wreg(sc, 8'hff);
        rreg(sc, 8'h03);
        wreg(ADDR_PIN_ENABLE, 8'ha5);
        rreg(ADDR_PIN_ENABLE, 8'ha5);
        wreg(ADDR_POLARITY, 8'h5a);
        rreg(ADDR_POLARITY, 8'h5a);
        wreg(sc, 8'h04);
        wreg(ADDR_PIN_ENABLE, 8'h00);
    endtask
    task automatic t_edge();
        dbg <= 1'b1;
        wreg(ADDR_POLARITY, 8'h00);
        wreg(ADDR_PIN_ENABLE, 8'h01);
        wreg(sc, 8'h04);
        wreg(sc, 8'h02);
        closed <= 8'h02;
        repeat (6) @(posedge clk);
        rreg(sc, 8'h02);
        closed <= 8'h01;
        repeat (6) @(posedge clk);
        #1 check({7'h0, irq}, 8'h01);
        closed <= 8'h00;
        repeat (6) @(posedge clk);
        rreg(sc, 8'h0a);
        wreg(sc, 8'h06);
        rreg(sc, 8'h02);
        #1 check({7'h0, irq}, 8'h00);
        dbg <= 1'b0;
        // back onto the clock edge before the next bus access
        @(posedge clk);
    endtask
    // pin idles at its active level when enabled, so only a full low-high cycle counts
    task automatic t_rise();
        slow <= 1'b1;
        wreg(sc, 8'h00);
        wreg(ADDR_POLARITY, 8'h04);
        wreg(ADDR_PIN_ENABLE, 8'h04);
        repeat (8) @(posedge clk);
        rreg(sc, 8'h00);
        closed <= 8'h04;
        repeat (8) @(posedge clk);
        rreg(sc, 8'h00);
        closed <= 8'h00;
        repeat (8) @(posedge clk);
        rreg(sc, 8'h08);
        wreg(sc, 8'h04);
        slow <= 1'b0;
    endtask
    task automatic t_level();
        pull_en <= 8'h05;
        wreg(ADDR_PIN_ENABLE, 8'h05);
        wreg(sc, 8'h05);
        #1 check(pull_up, 8'h01);
        check(pull_dn, 8'h04);
        closed <= 8'h01;
        repeat (6) @(posedge clk);
        rreg(sc, 8'h09);
        wreg(sc, 8'h05);
        rreg(sc, 8'h09);
        #1 check({7'h0, irq}, 8'h00);
        closed <= 8'h00;
        repeat (6) @(posedge clk);
        wreg(sc, 8'h05);
        rreg(sc, 8'h01);
    endtask
    task automatic t_power();
        wreg(sc, 8'h03);
        closed <= 8'h01;
        pmode <= PWR_WAIT;
        repeat (6) @(posedge clk);
        #1 check({7'h0, wake}, 8'h01);
        @(posedge clk);
        pmode <= PWR_STOP3;
        repeat (2) @(posedge clk);
        #1 check({7'h0, wake}, 8'h01);
        @(posedge clk);
        pmode <= PWR_DEEP;
        repeat (2) @(posedge clk);
        pmode <= PWR_RUN;
        closed <= 8'h00;
        rreg(ADDR_PIN_ENABLE, RESET_PIN_ENABLE);
        rreg(sc, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_edge();
        t_rise();
        t_level();
        t_power();
        finish_test();
    end
endmodule
